// ==== chi_defines.vh ====
// Shared constants of the card host interface: command codes and limits.
// Assumes inclusion by its bare name from every design file that needs it.
`ifndef CHI_DEFINES_VH
`define CHI_DEFINES_VH

// Transfer command codes on cmd_code
`define CHI_CMD_READ_SINGLE 3'h0
`define CHI_CMD_READ_MULTI 3'h1
`define CHI_CMD_WRITE_SINGLE 3'h2
`define CHI_CMD_WRITE_MULTI 3'h3
`define CHI_CMD_READ_STREAM 3'h4
`define CHI_CMD_WRITE_STREAM 3'h5
`define CHI_CMD_STOP 3'h6
`define CHI_CMD_STOP_SYNC 3'h7

// Shortest write the channel counters can start, in bytes
`define CHI_MIN_WRITE_BYTES 16'h000C

// Reset value and underrun fill word
`define CHI_RESET_WORD 32'h00000000
`define CHI_UNDERRUN_FILL 32'hFFFFFFFF

// Data word geometry
`define CHI_BYTES_PER_WORD 2'h3
`define CHI_BITS_PER_BYTE 3'h7

`endif

// ==== chi_sync.v ====
// Two-stage synchroniser for a bundle of asynchronous single-bit inputs.
// Assumes each bit is independent; no bus coherence across bits.
`timescale 1ns/1ps
module chi_sync #(
  parameter W = 2
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Asynchronous in, synchronous out
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] stage1;

  // First stage feeds only the second
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1 <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ==== chi_fifo.v ====
// Small synchronous FIFO with valid/ready on both sides and a clear.
// Assumes one clock; clear wins over any push or pop in the same cycle.
`timescale 1ns/1ps
module chi_fifo #(
  parameter W = 32,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  input wire clear,
  // Filling side
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  // Draining side
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  integer i;

  // Honest full and empty from the occupancy count
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at DEPTH, which need not be a power of two
  always @(posedge sys_clk) begin
    if (!rst_n || clear) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Storage; contents are don't-care once the pointers are cleared
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {W{1'b0}};
      end
    end else if (push) begin
      mem[wptr] <= in_data;
    end
  end

endmodule

// ==== chi_top.v ====
// Card host interface: block data engine between a word FIFO and a card data line.
// Assumes the card drives card_clk; data sampled on its rising edges, driven on falling.
// What this block does
// - Data words byte-swapped; commands unaffected.
// - Data timeout never flags; start wait unbounded.
// - Stream read/write commands are refused.
// - Unaligned multi-write ignores stop command.
// - Mid-block stop leaves active flag set.
// - Synchronised stop waits; receive-ready held low.
// - Every transfer command accepted in idle clears shared FIFO.
// - Data CRC error flag never asserts.
// - Mid-block read stop corrupts next reads.
// - Writes under twelve bytes are refused.
`timescale 1ns/1ps
`include "chi_defines.vh"
module chi_top #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2,
  parameter LEN_W = 12,
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  input wire soft_reset,
  // Command port
  input wire cmd_valid,
  input wire [2:0] cmd_code,
  input wire [LEN_W-1:0] block_length_field,
  input wire [CNT_W-1:0] dma_byte_count,
  output reg cmd_rejected,
  // Host data toward the card
  input wire [31:0] tx_data,
  input wire tx_valid,
  output wire tx_ready,
  // Host data from the card
  output wire [31:0] rx_data,
  output wire rx_valid,
  input wire rx_ready,
  // Status
  output reg data_transfer_active_flag,
  output wire receive_ready_flag,
  output wire transmit_ready_flag,
  output wire data_timeout_flag,
  output wire data_crc_error_flag,
  output reg overrun_flag,
  output reg underrun_flag,
  output reg read_state_corrupt,
  // Card data line
  input wire card_clk,
  input wire card_dat_in,
  output reg card_dat_out,
  output reg card_dat_oe
);

  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT_START = 3'h1;
  localparam ST_RX_BITS = 3'h2;
  localparam ST_TX_START = 3'h3;
  localparam ST_TX_BITS = 3'h4;
  localparam ST_TX_END = 3'h5;

  reg [2:0] state;
  reg dir_write;
  reg multi;
  reg stop_blocked;
  reg sync_stop_pending;
  reg [LEN_W-1:0] blk_len;
  reg [LEN_W-1:0] byte_cnt;
  reg [CNT_W-1:0] dma_left;
  reg [2:0] bit_cnt;
  reg [1:0] word_byte;
  reg [7:0] byte_sh;
  reg [31:0] word_sh;
  reg [31:0] push_data;
  reg push_valid;
  reg clk_d;
  reg fifo_clear;

  wire clk_s;
  wire dat_s;
  wire rise;
  wire fall;
  wire [31:0] fifo_in_data;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [31:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire tx_pop;
  wire is_xfer;
  wire is_stop;
  wire in_block;
  wire last_byte;
  wire [7:0] next_byte;
  wire [CNT_W-1:0] blk_len_w;
  wire [CNT_W-1:0] next_dma_left;
  wire more_blocks;

  // Card pins cross into sys_clk before any use
  chi_sync #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({card_dat_in, card_clk}),
    .sync_out({dat_s, clk_s})
  );

  // Edge finder runs on the synchronised copy only
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_d <= 1'b0;
    end else begin
      clk_d <= clk_s;
    end
  end

  assign rise = clk_s && !clk_d;
  assign fall = !clk_s && clk_d;

  // One shared FIFO; its filling side is the host on writes, the engine on reads
  chi_fifo #(.W(32), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear(fifo_clear),
    .in_data(fifo_in_data),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  assign fifo_in_data = dir_write ? tx_data : push_data;
  assign fifo_in_valid = dir_write ? tx_valid : push_valid;
  // Ready flags held low while the FIFO clear is in flight, so no word is lost to it
  assign tx_ready = dir_write && fifo_in_ready && !fifo_clear;
  assign transmit_ready_flag = tx_ready;
  // Receive-ready also hidden while a synchronised stop is pending
  assign receive_ready_flag = !dir_write && fifo_out_valid && !fifo_clear &&
                              !sync_stop_pending;
  assign rx_valid = receive_ready_flag;
  assign rx_data = fifo_out_data;
  // Word taken at a start bit or a later word boundary; the first word is already loaded
  assign tx_pop = dir_write && fall &&
                  ((state == ST_TX_START) ||
                   (state == ST_TX_BITS && bit_cnt == 3'h0 &&
                    word_byte == 2'h0 && byte_cnt != {LEN_W{1'b0}}));
  assign fifo_out_ready = dir_write ? tx_pop : (rx_ready && receive_ready_flag);

  // These error detectors are not wired in; waits are unbounded
  assign data_timeout_flag = 1'b0;
  assign data_crc_error_flag = 1'b0;

  assign is_xfer = (cmd_code == `CHI_CMD_READ_SINGLE) || (cmd_code == `CHI_CMD_READ_MULTI) ||
                   (cmd_code == `CHI_CMD_WRITE_SINGLE) || (cmd_code == `CHI_CMD_WRITE_MULTI);
  assign is_stop = (cmd_code == `CHI_CMD_STOP) || (cmd_code == `CHI_CMD_STOP_SYNC);
  assign in_block = (state == ST_RX_BITS) || (state == ST_TX_BITS) || (state == ST_TX_END);
  assign last_byte = (byte_cnt == blk_len - 1'b1) && (bit_cnt == `CHI_BITS_PER_BYTE);
  assign next_byte = {byte_sh[6:0], dat_s};
  assign blk_len_w = {{(CNT_W-LEN_W){1'b0}}, blk_len};
  assign next_dma_left = (dma_left > blk_len_w) ? dma_left - blk_len_w : {CNT_W{1'b0}};
  assign more_blocks = multi && (next_dma_left != {CNT_W{1'b0}});

  // Main engine; commands are taken only here
  always @(posedge sys_clk) begin
    if (!rst_n || soft_reset) begin
      state <= ST_IDLE;
      dir_write <= 1'b0;
      multi <= 1'b0;
      stop_blocked <= 1'b0;
      sync_stop_pending <= 1'b0;
      blk_len <= {LEN_W{1'b0}};
      byte_cnt <= {LEN_W{1'b0}};
      dma_left <= {CNT_W{1'b0}};
      bit_cnt <= 3'h0;
      word_byte <= 2'h0;
      byte_sh <= 8'h00;
      word_sh <= `CHI_RESET_WORD;
      push_data <= `CHI_RESET_WORD;
      push_valid <= 1'b0;
      fifo_clear <= 1'b0;
      cmd_rejected <= 1'b0;
      data_transfer_active_flag <= 1'b0;
      overrun_flag <= 1'b0;
      underrun_flag <= 1'b0;
      read_state_corrupt <= 1'b0;
      card_dat_out <= 1'b1;
      card_dat_oe <= 1'b0;
    end else begin
      push_valid <= 1'b0;
      fifo_clear <= 1'b0;
      cmd_rejected <= 1'b0;
      // Stream commands and too-short writes never start
      if (cmd_valid && !is_xfer && !is_stop) begin
        cmd_rejected <= 1'b1;
      end else if (cmd_valid && is_xfer && cmd_code[1] &&
                   dma_byte_count < `CHI_MIN_WRITE_BYTES) begin
        cmd_rejected <= 1'b1;
      end else if (cmd_valid && is_xfer && (state == ST_IDLE)) begin
        fifo_clear <= 1'b1;
        dir_write <= cmd_code[1];
        multi <= cmd_code[0];
        blk_len <= block_length_field;
        dma_left <= dma_byte_count;
        // Multi-write whose size does not divide cannot be stopped
        stop_blocked <= (cmd_code == `CHI_CMD_WRITE_MULTI) && (block_length_field != 0) &&
                        ((dma_byte_count % block_length_field) != 0);
        sync_stop_pending <= 1'b0;
        byte_cnt <= {LEN_W{1'b0}};
        bit_cnt <= 3'h0;
        word_byte <= 2'h0;
        data_transfer_active_flag <= 1'b1;
        state <= cmd_code[1] ? ST_TX_START : ST_WAIT_START;
      end else if (cmd_valid && (cmd_code == `CHI_CMD_STOP) && !stop_blocked &&
                   (state != ST_IDLE)) begin
        state <= ST_IDLE;
        card_dat_oe <= 1'b0;
        card_dat_out <= 1'b1;
        if (in_block) begin
          // Aborted block leaves the active flag set, and the read state broken if it was a read
          data_transfer_active_flag <= 1'b1;
          if (!dir_write) begin
            read_state_corrupt <= 1'b1;
          end
        end else begin
          data_transfer_active_flag <= 1'b0;
        end
      end else if (cmd_valid && (cmd_code == `CHI_CMD_STOP_SYNC) && !stop_blocked &&
                   (state != ST_IDLE)) begin
        sync_stop_pending <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: card_dat_oe <= 1'b0;
          // No timeout here: only a plain stop or a reset ends this wait; a synchronised stop does not
          ST_WAIT_START: begin
            if (rise && !dat_s) begin
              state <= ST_RX_BITS;
              byte_cnt <= {LEN_W{1'b0}};
            end
          end
          ST_RX_BITS: begin
            if (rise) begin
              byte_sh <= next_byte;
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == `CHI_BITS_PER_BYTE) begin
                // First byte lands in the top lane: byte order swapped
                word_sh <= {word_sh[23:0], next_byte};
                word_byte <= word_byte + 1'b1;
                byte_cnt <= byte_cnt + 1'b1;
                if (word_byte == `CHI_BYTES_PER_WORD || last_byte) begin
                  push_data <= read_state_corrupt ? ~{word_sh[23:0], next_byte} :
                               {word_sh[23:0], next_byte};
                  push_valid <= 1'b1;
                  word_byte <= 2'h0;
                  // Card cannot be held back; a full FIFO loses the word
                  if (!fifo_in_ready) begin
                    overrun_flag <= 1'b1;
                  end
                end
                if (last_byte) begin
                  dma_left <= next_dma_left;
                  if (more_blocks && !sync_stop_pending) begin
                    state <= ST_WAIT_START;
                  end else begin
                    state <= ST_IDLE;
                    sync_stop_pending <= 1'b0;
                    data_transfer_active_flag <= 1'b0;
                  end
                end
              end
            end
          end
          // Start bit goes out once a word is ready to follow it
          ST_TX_START: begin
            if (fall && fifo_out_valid && !fifo_clear) begin
              card_dat_oe <= 1'b1;
              card_dat_out <= 1'b0;
              word_sh <= fifo_out_data;
              byte_cnt <= {LEN_W{1'b0}};
              bit_cnt <= 3'h0;
              word_byte <= 2'h0;
              state <= ST_TX_BITS;
            end
          end
          ST_TX_BITS: begin
            if (fall) begin
              // Top lane sent first, mirroring the receive swap
              if (bit_cnt == 3'h0 && word_byte == 2'h0 && byte_cnt != 0) begin
                card_dat_out <= fifo_out_valid ? fifo_out_data[31] : 1'b1;
                word_sh <= fifo_out_valid ? {fifo_out_data[30:0], 1'b0} :
                           `CHI_UNDERRUN_FILL;
                if (!fifo_out_valid) begin
                  underrun_flag <= 1'b1;
                end
              end else begin
                card_dat_out <= word_sh[31];
                word_sh <= {word_sh[30:0], 1'b0};
              end
              bit_cnt <= bit_cnt + 1'b1;
              if (bit_cnt == `CHI_BITS_PER_BYTE) begin
                word_byte <= word_byte + 1'b1;
                byte_cnt <= byte_cnt + 1'b1;
                if (last_byte) begin
                  state <= ST_TX_END;
                end
              end
            end
          end
          // End bit; the card's CRC status that follows is not examined
          ST_TX_END: begin
            if (fall) begin
              card_dat_out <= 1'b1;
              dma_left <= next_dma_left;
              if (more_blocks && !sync_stop_pending) begin
                state <= ST_TX_START;
              end else begin
                state <= ST_IDLE;
                sync_stop_pending <= 1'b0;
                data_transfer_active_flag <= 1'b0;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// ==== chi_top_monitor.sv ====
// Checker for the card host interface top: command answers and status flags.
// Assumes it is bound into chi_top and sees only that module's ports.
`timescale 1ns/1ps
module chi_top_monitor #(
  parameter LEN_W = 12,
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  // Command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [LEN_W-1:0] block_length_field,
  input wire logic [CNT_W-1:0] dma_byte_count,
  input wire logic cmd_rejected,
  // Handshakes and status
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic transmit_ready_flag,
  input wire logic data_transfer_active_flag,
  input wire logic data_timeout_flag,
  input wire logic data_crc_error_flag,
  input wire logic read_state_corrupt
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic unal;
  // Commands that must be refused: stream codes, writes under the minimum
  wire rej_now = cmd_valid && (cmd_code inside {3'h4, 3'h5} ||
    (cmd_code inside {3'h2, 3'h3} && dma_byte_count < 16'h000C));

  // Unaligned multi-write in flight; cleared once the engine goes quiet
  always @(posedge sys_clk) begin
    if (!rst_n || soft_reset)
      unal <= 1'b0;
    else if (cmd_valid && !data_transfer_active_flag)
      unal <= cmd_code == 3'h3 && !rej_now && dma_byte_count % block_length_field != 0;
    else if (!data_transfer_active_flag)
      unal <= 1'b0;
  end

  property p_rej_fwd;
    rej_now && !soft_reset |=> cmd_rejected;
  endproperty
  a_rej_fwd: assert property (p_rej_fwd) else $error("refusal missing");
  property p_rej_cause;
    cmd_rejected |-> $past(rej_now);
  endproperty
  a_rej_cause: assert property (p_rej_cause) else $error("refusal without cause");
  property p_no_tmo;
    !data_timeout_flag;
  endproperty
  a_no_tmo: assert property (p_no_tmo) else $error("timeout flag rose");
  property p_no_crc;
    !data_crc_error_flag;
  endproperty
  a_no_crc: assert property (p_no_crc) else $error("crc flag rose");
  property p_fifo_clr;
    cmd_valid && cmd_code[2:1] == 2'h0 && !data_transfer_active_flag && !soft_reset
      |=> data_transfer_active_flag && !rx_valid;
  endproperty
  a_fifo_clr: assert property (p_fifo_clr) else $error("fifo not cleared at read start");
  property p_stop_unal;
    unal && cmd_valid && cmd_code[2:1] == 2'h3 && !soft_reset |=> data_transfer_active_flag;
  endproperty
  a_stop_unal: assert property (p_stop_unal) else $error("unaligned write stopped");
  property p_corrupt;
    read_state_corrupt && !soft_reset |=> read_state_corrupt;
  endproperty
  a_corrupt: assert property (p_corrupt) else $error("corrupt state lost");
  property p_tx_flag;
    transmit_ready_flag == tx_ready;
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("tx flag differs from ready");
  c_rej: cover property (cmd_rejected);
  c_corrupt: cover property ($rose(read_state_corrupt));
  c_unal_stop: cover property (unal && cmd_valid && cmd_code == 3'h6);
  c_sync_stop: cover property (cmd_valid && cmd_code == 3'h7 && data_transfer_active_flag);
endmodule

bind chi_top chi_top_monitor #(.LEN_W(LEN_W), .CNT_W(CNT_W)) mon (.sys_clk, .rst_n,
  .soft_reset, .cmd_valid, .cmd_code, .block_length_field, .dma_byte_count, .cmd_rejected,
  .tx_ready, .rx_valid, .transmit_ready_flag, .data_transfer_active_flag,
  .data_timeout_flag, .data_crc_error_flag, .read_state_corrupt);

// ==== chi_card_model.sv ====
// Behavioural memory card on the data line: sends and receives framed blocks.
// Assumes a pulled-up data line; the card clock runs only while a task ticks it, in or out of frames.
`timescale 1ns/1ps
module chi_card_model (
  // Card data line
  output logic card_clk,
  output logic card_dat_in,
  input wire logic card_dat_out,
  input wire logic card_dat_oe
);
  // Idle: clock still, line at its pull-up level
  initial begin
    card_clk = 1'b0;
    card_dat_in = 1'b1;
  end

  // One 200 ns link cycle; host output sampled late, clear of its latency
  task automatic tick(input logic b, output logic s);
    card_dat_in = b;
    #100 card_clk = 1'b1;
    #90 s = card_dat_out;
    #10 card_clk = 1'b0;
  endtask

  // Start bit then n bytes, first byte from the top; no timeout on start
  task automatic send(input logic [63:0] d, input int n);
    logic s;
    tick(1'b0, s);
    for (int i = 0; i < n * 8; i++)
      tick(d[63 - i], s);
    card_dat_in = 1'b1;
  endtask

  // Clock without data, as a card that never starts would
  task automatic idle(input int n);
    logic s;
    repeat (n) tick(1'b1, s);
  endtask

  // Wait for the host start bit, collect n bits, then clock the end bit
  task automatic recv(input int n, output logic [127:0] v);
    logic s;
    s = 1'b1;
    for (int k = 0; k < 16 && (s || !card_dat_oe); k++)
      tick(1'b1, s);
    v = '0;
    for (int i = 0; i < n; i++) begin
      tick(1'b1, s);
      v = {v[126:0], s};
    end
    tick(1'b1, s);
  endtask
endmodule

// ==== chi_top_tb.sv ====
// Self-checking bench for chi_top: command calls, host words and card frames.
// Assumes chi_card_model on the data line and the bound checker beside the top.
`timescale 1ns/1ps
module chi_top_tb;
  logic sys_clk, rst_n, soft_reset, cmd_valid, tx_valid, rx_ready, rej;
  logic [2:0] cmd_code;
  logic [11:0] block_length_field;
  logic [15:0] dma_byte_count;
  logic [31:0] tx_data, rx_data;
  logic cmd_rejected, tx_ready, rx_valid, data_transfer_active_flag, receive_ready_flag;
  logic transmit_ready_flag, data_timeout_flag, data_crc_error_flag, overrun_flag;
  logic underrun_flag, read_state_corrupt, card_clk, card_dat_in, card_dat_out, card_dat_oe;
  logic [127:0] bits;
  int failures, checks_done, cycles;

  chi_top dut (.sys_clk, .rst_n, .soft_reset, .cmd_valid, .cmd_code, .block_length_field,
    .dma_byte_count, .cmd_rejected, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_ready, .data_transfer_active_flag, .receive_ready_flag, .transmit_ready_flag,
    .data_timeout_flag, .data_crc_error_flag, .overrun_flag, .underrun_flag,
    .read_state_corrupt, .card_clk, .card_dat_in, .card_dat_out, .card_dat_oe);
  chi_card_model card (.card_clk, .card_dat_in, .card_dat_out, .card_dat_oe);

  // 40 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle command; refusal sampled in the cycle it stands
  task automatic cmd(input logic [2:0] c, input logic [11:0] l, input logic [15:0] n);
    @(negedge sys_clk);
    cmd_code = c;
    block_length_field = l;
    dma_byte_count = n;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    rej = cmd_rejected;
  endtask

  // Called at a falling edge; valid stays up for the caller to drop after the last word
  task automatic push(input logic [31:0] w);
    tx_data = w;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask

  // Pop only while data is offered
  task automatic pop(input logic [31:0] exp);
    @(negedge sys_clk);
    while (rx_valid !== 1'b1) @(negedge sys_clk);
    chk(rx_data, exp);
    rx_ready = 1'b1;
    @(negedge sys_clk);
    rx_ready = 1'b0;
  endtask

  task automatic srst;
    @(negedge sys_clk);
    soft_reset = 1'b1;
    @(negedge sys_clk);
    soft_reset = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, soft_reset, cmd_valid, tx_valid, rx_ready} = 5'h00;
    cmd_code = 3'h0;
    block_length_field = 12'h000;
    dma_byte_count = 16'h0000;
    tx_data = 32'h00000000;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    // Short writes and both stream codes are refused
    for (int i = 2; i < 6; i++) begin
      cmd(3'(i), 12'h00C, 16'h000B);
      chk({rej, data_transfer_active_flag}, 32'h2);
    end
    // Read: first byte off the card lands in the top byte
    cmd(3'h0, 12'h008, 16'h0008);
    card.send(64'h1112131415161718, 8);
    pop(32'h11121314);
    pop(32'h15161718);
    repeat (4) @(negedge sys_clk);
    chk(data_transfer_active_flag, 1'b0);
    // Unread word is thrown away by the next command; start never comes
    cmd(3'h0, 12'h004, 16'h0004);
    card.send(64'hA1B2C3D400000000, 4);
    repeat (6) @(negedge sys_clk);
    chk(rx_valid, 1'b1);
    cmd(3'h0, 12'h004, 16'h0004);
    chk(rx_valid, 1'b0);
    @(negedge sys_clk);
    chk(rx_valid, 1'b0);
    card.idle(20);
    chk({data_transfer_active_flag, data_timeout_flag}, 32'h2);
    cmd(3'h6, 12'h004, 16'h0004);
    repeat (2) @(negedge sys_clk);
    chk(data_transfer_active_flag, 1'b0);
    // Synchronised stop between blocks: data still lands, receive-ready hidden
    cmd(3'h1, 12'h004, 16'h0008);
    card.send(64'h2122232400000000, 4);
    cmd(3'h7, 12'h004, 16'h0008);
    chk(rx_valid, 1'b0);
    card.send(64'h3132333400000000, 4);
    pop(32'h21222324);
    pop(32'h31323334);
    chk(data_transfer_active_flag, 1'b0);
    // Multi-block read stopped inside a block
    cmd(3'h1, 12'h008, 16'h0010);
    card.send(64'h0102030000000000, 3);
    cmd(3'h6, 12'h008, 16'h0010);
    repeat (2) @(negedge sys_clk);
    chk({data_transfer_active_flag, read_state_corrupt}, 32'h3);
    // A read after the broken stop comes back corrupted
    cmd(3'h0, 12'h004, 16'h0004);
    card.send(64'hA1B2C3D400000000, 4);
    pop(32'h5E4D3C2B);
    srst;
    chk({data_transfer_active_flag, read_state_corrupt}, 32'h0);
    cmd(3'h0, 12'h004, 16'h0004);
    card.send(64'hA1B2C3D400000000, 4);
    pop(32'hA1B2C3D4);
    // Multi-write whose count is not a block multiple ignores stop
    cmd(3'h3, 12'h00C, 16'h0010);
    chk(rej, 1'b0);
    cmd(3'h6, 12'h00C, 16'h0010);
    @(negedge sys_clk);
    chk(data_transfer_active_flag, 1'b1);
    srst;
    // Write: fill the FIFO with the card stalled, then drain on the line
    cmd(3'h2, 12'h010, 16'h0010);
    for (int i = 0; i < 4; i++)
      push(32'h10203040 + i);
    tx_valid = 1'b0;
    chk(tx_ready, 1'b0);
    card.recv(128, bits);
    for (int i = 0; i < 4; i++)
      chk(bits[127 - 32 * i -: 32], 32'h10203040 + i);
    repeat (6) @(negedge sys_clk);
    chk({data_transfer_active_flag, data_crc_error_flag}, 32'h0);
    // Write under the minimum: counters padded, real length in the block field
    cmd(3'h2, 12'h008, 16'h000C);
    chk(rej, 1'b0);
    push(32'h55667788);
    push(32'h99AABBCC);
    tx_valid = 1'b0;
    card.recv(64, bits);
    chk(bits[63:32], 32'h55667788);
    chk(bits[31:0], 32'h99AABBCC);
    repeat (6) @(negedge sys_clk);
    chk({overrun_flag, underrun_flag, receive_ready_flag, card_dat_oe}, 32'h0);
    complete_run;
  end
endmodule
